// ===== rtl/smc_pkg.sv
package smc_pkg;
  localparam int unsigned SMC_ADDR_W   = 16;
  localparam int unsigned SMC_DATA_W   = 8;
  // memory cycle length in ns (ref_clk period is 100 ns)
  localparam int unsigned SMC_CYC_NS   = 300;
  localparam int unsigned SMC_CLK_NS   = 100;
  localparam int unsigned SMC_CYC_CLKS = (SMC_CYC_NS + SMC_CLK_NS - 1) / SMC_CLK_NS;
  localparam int unsigned SMC_CNT_W    = 4;
  localparam logic [SMC_CNT_W-1:0] SMC_CNT_LAST = SMC_CNT_W'(SMC_CYC_CLKS - 1);
  localparam logic [SMC_CNT_W-1:0] SMC_CNT_ZERO = 4'h0;

  typedef enum logic {
    SMC_OWNER_COMM,
    SMC_OWNER_HOST
  } smc_owner_t;

  typedef enum {
    SMC_IDLE,
    SMC_BUSY
  } smc_state_t;
endpackage

// ===== rtl/smc_if.sv
`timescale 1ns/100ps
interface smc_if;
  // host bus request side
  logic                              hostReq;
  logic                              hostWrite;
  logic [smc_pkg::SMC_ADDR_W-1:0]    hostAddr;
  logic [smc_pkg::SMC_DATA_W-1:0]    hostWdata;
  logic                              hostReady;
  logic [smc_pkg::SMC_DATA_W-1:0]    hostRdata;
  // interrupt pins
  logic                              hostIrqClearPulse;
  logic                              commIrqSetPulse;
  logic                              host_irq_request_out;

  modport device (
    input  hostReq, hostWrite, hostAddr, hostWdata, hostIrqClearPulse, commIrqSetPulse,
    output hostReady, hostRdata, host_irq_request_out
  );
  modport host (
    output hostReq, hostWrite, hostAddr, hostWdata, hostIrqClearPulse, commIrqSetPulse,
    input  hostReady, hostRdata, host_irq_request_out
  );
endinterface

// ===== rtl/smc_shared_memory_controller.sv
`timescale 1ns/100ps
module smc_shared_memory_controller (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  smc_if.device                               hostBus,
  // communications processor side
  input  wire logic                           commReq,
  input  wire logic                           commWrite,
  input  wire logic [smc_pkg::SMC_ADDR_W-1:0] commAddr,
  input  wire logic [smc_pkg::SMC_DATA_W-1:0] commWdata,
  input  wire logic                           commIrqSetHost,
  input  wire logic                           commIrqAck,
  output logic                                commReady,
  output logic      [smc_pkg::SMC_DATA_W-1:0] commRdata,
  output logic                                commIrqPending,
  // static RAM and bus interface block controls
  output logic      [smc_pkg::SMC_ADDR_W-1:0] ramAddr,
  output logic      [smc_pkg::SMC_DATA_W-1:0] ramWdata,
  input  wire logic [smc_pkg::SMC_DATA_W-1:0] ramRdata,
  output logic                                ramSel_n,
  output logic                                ramOutEn_n,
  output logic                                ramWrEn_n,
  output logic                                ramDataOe_n,
  output logic                                hostBufEn_n,
  output logic                                commBufEn_n,
  output logic                                hostRdLatch,
  output logic                                commRdLatch
);
  // ==========================================================
  // arbitration and cycle timing
  smc_pkg::smc_state_t              state, next_state;
  smc_pkg::smc_owner_t              owner, next_owner;
  logic                             favourHost, next_favourHost;
  logic [smc_pkg::SMC_CNT_W-1:0]    cnt, next_cnt;
  logic                             isWrite, next_isWrite;
  logic [smc_pkg::SMC_ADDR_W-1:0]   next_ramAddr;
  logic [smc_pkg::SMC_DATA_W-1:0]   next_ramWdata;
  logic                             lastClk;

  function automatic logic inCycle(input smc_pkg::smc_state_t s);
    return s == smc_pkg::SMC_BUSY;
  endfunction

  assign lastClk = inCycle(state) && (cnt == smc_pkg::SMC_CNT_LAST);

  always_comb begin
    next_state      = state;
    next_owner      = owner;
    next_favourHost = favourHost;
    next_cnt        = cnt;
    next_isWrite    = isWrite;
    next_ramAddr    = ramAddr;
    next_ramWdata   = ramWdata;
    unique case (state)
      smc_pkg::SMC_IDLE: begin
        if (hostBus.hostReq || commReq) begin
          if (hostBus.hostReq && (!commReq || favourHost)) begin
            next_owner      = smc_pkg::SMC_OWNER_HOST;
            next_isWrite    = hostBus.hostWrite;
            next_ramAddr    = hostBus.hostAddr;
            next_ramWdata   = hostBus.hostWdata;
            next_favourHost = 1'b0;
          end else begin
            next_owner      = smc_pkg::SMC_OWNER_COMM;
            next_isWrite    = commWrite;
            next_ramAddr    = commAddr;
            next_ramWdata   = commWdata;
            next_favourHost = 1'b1;
          end
          next_state = smc_pkg::SMC_BUSY;
          next_cnt   = smc_pkg::SMC_CNT_ZERO;
        end
      end
      smc_pkg::SMC_BUSY: begin
        if (lastClk) begin
          next_state = smc_pkg::SMC_IDLE;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state      <= smc_pkg::SMC_IDLE;
      owner      <= smc_pkg::SMC_OWNER_COMM;
      favourHost <= 1'b0;
      cnt        <= smc_pkg::SMC_CNT_ZERO;
      isWrite    <= 1'b0;
      ramAddr    <= '0;
      ramWdata   <= '0;
    end else begin
      state      <= next_state;
      owner      <= next_owner;
      favourHost <= next_favourHost;
      cnt        <= next_cnt;
      isWrite    <= next_isWrite;
      ramAddr    <= next_ramAddr;
      ramWdata   <= next_ramWdata;
    end
  end

  // ==========================================================
  // strobes and buffer controls
  // registered from next values so a decode glitch never reaches the ram strobes
  logic busyAhead;
  logic hostOwnsAhead;
  logic lastAhead;
  logic next_ramSel_n;
  logic next_ramOutEn_n;
  logic next_ramWrEn_n;
  logic next_ramDataOe_n;
  logic next_hostBufEn_n;
  logic next_commBufEn_n;
  logic next_hostRdLatch;
  logic next_commRdLatch;

  always_comb begin
    busyAhead     = inCycle(next_state);
    hostOwnsAhead = (next_owner == smc_pkg::SMC_OWNER_HOST);
    lastAhead     = busyAhead && (next_cnt == smc_pkg::SMC_CNT_LAST);
    next_ramSel_n    = !busyAhead;
    next_ramOutEn_n  = !(busyAhead && !next_isWrite);
    // write strobe skips first clock so address settles
    next_ramWrEn_n   = !(busyAhead && next_isWrite && (next_cnt != smc_pkg::SMC_CNT_ZERO));
    next_ramDataOe_n = !(busyAhead && next_isWrite);
    next_hostBufEn_n = !(busyAhead && hostOwnsAhead);
    next_commBufEn_n = !(busyAhead && !hostOwnsAhead);
    next_hostRdLatch = lastAhead && hostOwnsAhead && !next_isWrite;
    next_commRdLatch = lastAhead && !hostOwnsAhead && !next_isWrite;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ramSel_n    <= 1'b1;
      ramOutEn_n  <= 1'b1;
      ramWrEn_n   <= 1'b1;
      ramDataOe_n <= 1'b1;
      hostBufEn_n <= 1'b1;
      commBufEn_n <= 1'b1;
      hostRdLatch <= 1'b0;
      commRdLatch <= 1'b0;
    end else begin
      ramSel_n    <= next_ramSel_n;
      ramOutEn_n  <= next_ramOutEn_n;
      ramWrEn_n   <= next_ramWrEn_n;
      ramDataOe_n <= next_ramDataOe_n;
      hostBufEn_n <= next_hostBufEn_n;
      commBufEn_n <= next_commBufEn_n;
      hostRdLatch <= next_hostRdLatch;
      commRdLatch <= next_commRdLatch;
    end
  end

  logic hostOwns;
  assign hostOwns = (owner == smc_pkg::SMC_OWNER_HOST);

  // ready held low until own cycle ends
  assign hostBus.hostReady = lastClk && hostOwns;
  assign commReady         = lastClk && !hostOwns;

  logic [smc_pkg::SMC_DATA_W-1:0] hostRd;
  logic [smc_pkg::SMC_DATA_W-1:0] next_hostRd;
  logic [smc_pkg::SMC_DATA_W-1:0] next_commRdata;

  always_comb begin
    next_hostRd    = hostRd;
    next_commRdata = commRdata;
    if (hostRdLatch) begin
      next_hostRd = ramRdata;
    end
    if (commRdLatch) begin
      next_commRdata = ramRdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostRd    <= '0;
      commRdata <= '0;
    end else begin
      hostRd    <= next_hostRd;
      commRdata <= next_commRdata;
    end
  end
  assign hostBus.hostRdata = hostRd;

  // ==========================================================
  // interprocessor interrupts
  logic hostIrq, next_hostIrq;
  logic next_commIrq;

  always_comb begin
    next_hostIrq = (hostIrq && !hostBus.hostIrqClearPulse) || commIrqSetHost;
    next_commIrq = (commIrqPending && !commIrqAck) || hostBus.commIrqSetPulse;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostIrq        <= 1'b0;
      commIrqPending <= 1'b0;
    end else begin
      hostIrq        <= next_hostIrq;
      commIrqPending <= next_commIrq;
    end
  end
  assign hostBus.host_irq_request_out = hostIrq;
endmodule // smc_shared_memory_controller

// ===== rtl/smc_host_end.sv
`timescale 1ns/100ps
module smc_host_end (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  smc_if.host                                 hostBus,
  input  wire logic                           userReq,
  input  wire logic                           userWrite,
  input  wire logic [smc_pkg::SMC_ADDR_W-1:0] userAddr,
  input  wire logic [smc_pkg::SMC_DATA_W-1:0] userWdata,
  input  wire logic                           userIrqAck,
  input  wire logic                           userRaiseIrq,
  output logic                                userBusy,
  output logic                                userDone,
  output logic      [smc_pkg::SMC_DATA_W-1:0] userRdata,
  output logic                                userIrq
);
  // ==========================================================
  // bus request, held until ready
  logic                           pend, next_pend;
  logic                           wr, next_wr;
  logic [smc_pkg::SMC_ADDR_W-1:0] addr, next_addr;
  logic [smc_pkg::SMC_DATA_W-1:0] wdata, next_wdata;
  logic [smc_pkg::SMC_DATA_W-1:0] next_rdata;
  logic                           next_done;
  logic                           fin, next_fin;
  logic                           clrP, next_clrP;
  logic                           setP, next_setP;

  always_comb begin
    next_pend  = pend;
    next_wr    = wr;
    next_addr  = addr;
    next_wdata = wdata;
    next_rdata = userRdata;
    // read data is registered in the controller, so it is taken one clock after ready
    next_done  = fin;
    next_fin   = 1'b0;
    if (pend && hostBus.hostReady) begin
      next_pend = 1'b0;
      next_fin  = 1'b1;
    end else if (!pend && userReq) begin
      next_pend  = 1'b1;
      next_wr    = userWrite;
      next_addr  = userAddr;
      next_wdata = userWdata;
    end
    if (fin && !wr) begin
      next_rdata = hostBus.hostRdata;
    end
    next_clrP = userIrqAck;
    next_setP = userRaiseIrq;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend      <= 1'b0;
      wr        <= 1'b0;
      addr      <= '0;
      wdata     <= '0;
      userRdata <= '0;
      userDone  <= 1'b0;
      fin       <= 1'b0;
      clrP      <= 1'b0;
      setP      <= 1'b0;
    end else begin
      pend      <= next_pend;
      wr        <= next_wr;
      addr      <= next_addr;
      wdata     <= next_wdata;
      userRdata <= next_rdata;
      userDone  <= next_done;
      fin       <= next_fin;
      clrP      <= next_clrP;
      setP      <= next_setP;
    end
  end

  assign hostBus.hostReq           = pend;
  assign hostBus.hostWrite         = wr;
  assign hostBus.hostAddr          = addr;
  assign hostBus.hostWdata         = wdata;
  assign hostBus.hostIrqClearPulse = clrP;
  assign hostBus.commIrqSetPulse   = setP;
  assign userBusy                  = pend;
  assign userIrq                   = hostBus.host_irq_request_out;
endmodule // smc_host_end

// ===== dv/smc_link_sva.sv
`timescale 1ns/100ps
module smc_link_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hostReq,
  input wire logic hostReady,
  input wire logic hostIrqClearPulse,
  input wire logic commIrqSetPulse,
  input wire logic host_irq_request_out,
  input wire logic commReq,
  input wire logic commReady,
  input wire logic commIrqSetHost,
  input wire logic commIrqAck,
  input wire logic commIrqPending
);
  // ==========================================
  // link checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ready_exclusive: assert property (!(hostReady && commReady))
    else $error("both readies high");
  a_ready_pulse: assert property (hostReady |=> !hostReady)
    else $error("host ready too long");
  a_host_answer: assert property ($rose(hostReq) |-> !hostReady[*3] ##[1:5] hostReady)
    else $error("host answer timing");
  a_comm_answer: assert property ($rose(commReq) |-> !commReady[*3] ##[1:5] commReady)
    else $error("comm answer timing");
  a_host_follows: assert property (commReady && hostReq |-> ##4 hostReady)
    else $error("host not next");
  a_comm_follows: assert property (hostReady && commReq |-> ##4 commReady)
    else $error("comm not next");
  a_host_irq_set: assert property (commIrqSetHost |=> host_irq_request_out)
    else $error("host irq not set");
  a_host_irq_clr: assert property (hostIrqClearPulse && !commIrqSetHost |=> !host_irq_request_out)
    else $error("host irq not cleared");
  a_host_irq_hold: assert property (host_irq_request_out && !hostIrqClearPulse |=> host_irq_request_out)
    else $error("host irq dropped");
  a_comm_irq_set: assert property (commIrqSetPulse |=> commIrqPending)
    else $error("comm irq not set");
  a_comm_irq_clr: assert property (commIrqAck && !commIrqSetPulse |=> !commIrqPending)
    else $error("comm irq not cleared");
  a_comm_irq_rise: assert property ($rose(commIrqPending) |-> $past(commIrqSetPulse))
    else $error("comm irq rose alone");
endmodule // smc_link_sva

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        ref_clk, rst, userReq, userWrite, userIrqAck, userRaiseIrq;
  logic        commReq, commWrite, commIrqSetHost, commIrqAck;
  logic        userBusy, userDone, userIrq, commReady, commIrqPending;
  logic        ramSel_n, ramWrEn_n, hostBufEn_n, commBufEn_n;
  logic        ramOutEn_n, ramDataOe_n, hostRdLatch, commRdLatch;
  logic [15:0] userAddr, commAddr, ramAddr;
  logic [7:0]  userWdata, commWdata, userRdata, commRdata, ramWdata, ramRdata;
  logic [7:0]  mem [16];
  int          n_mismatch, check_count, cycles;
  smc_if       link ();
  smc_host_end i_smc_host_end (.ref_clk(ref_clk), .rst(rst), .hostBus(link),
    .userReq(userReq), .userWrite(userWrite), .userAddr(userAddr), .userWdata(userWdata),
    .userIrqAck(userIrqAck), .userRaiseIrq(userRaiseIrq), .userBusy(userBusy),
    .userDone(userDone), .userRdata(userRdata), .userIrq(userIrq));
  smc_shared_memory_controller i_smc_shared_memory_controller (.ref_clk(ref_clk),
    .rst(rst), .hostBus(link), .commReq(commReq), .commWrite(commWrite),
    .commAddr(commAddr), .commWdata(commWdata), .commIrqSetHost(commIrqSetHost),
    .commIrqAck(commIrqAck), .commReady(commReady), .commRdata(commRdata),
    .commIrqPending(commIrqPending), .ramAddr(ramAddr), .ramWdata(ramWdata),
    .ramRdata(ramRdata), .ramSel_n(ramSel_n), .ramOutEn_n(ramOutEn_n), .ramWrEn_n(ramWrEn_n),
    .ramDataOe_n(ramDataOe_n), .hostBufEn_n(hostBufEn_n), .commBufEn_n(commBufEn_n),
    .hostRdLatch(hostRdLatch), .commRdLatch(commRdLatch));
  smc_link_sva i_smc_link_sva (.ref_clk(ref_clk), .rst(rst), .hostReq(link.hostReq),
    .hostReady(link.hostReady), .hostIrqClearPulse(link.hostIrqClearPulse),
    .commIrqSetPulse(link.commIrqSetPulse), .host_irq_request_out(link.host_irq_request_out),
    .commReq(commReq), .commReady(commReady), .commIrqSetHost(commIrqSetHost),
    .commIrqAck(commIrqAck), .commIrqPending(commIrqPending));
  // ==========================================
  // ram model, clock, timeout
  assign ramRdata = mem[ramAddr[3:0]];
  always @(posedge ref_clk) if (!ramSel_n && !ramWrEn_n) mem[ramAddr[3:0]] <= ramWdata;
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // whole run is well under two hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end
  // ==========================================
  // tasks
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic host_acc(logic w, logic [15:0] a, logic [7:0] d);
    int k;
    userWrite = w;
    userAddr = a;
    userWdata = d;
    userReq = 1'b1;
    for (k = 0; k < 20 && userDone !== 1'b1; k++) begin
      @(negedge ref_clk);
      if (userBusy === 1'b1) userReq = 1'b0;
    end
    @(negedge ref_clk);
  endtask
  task automatic comm_acc(logic w, logic [15:0] a, logic [7:0] d);
    int k;
    commWrite = w;
    commAddr = a;
    commWdata = d;
    commReq = 1'b1;
    for (k = 0; k < 20 && commReady !== 1'b1; k++) @(negedge ref_clk);
    @(negedge ref_clk);
    commReq = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic t_conflict();
    int k, cr, hr;
    cr = -1;
    hr = -1;
    userWrite = 1'b1;
    userAddr = 16'h0001;
    userWdata = 8'h11;
    userReq = 1'b1;
    for (k = 0; k < 10 && link.hostReq !== 1'b1; k++) @(negedge ref_clk);
    commWrite = 1'b1;
    commAddr = 16'h0002;
    commWdata = 8'h22;
    commReq = 1'b1;
    for (k = 0; k < 16; k++) begin
      if (commReady === 1'b1) cr = k;
      if (commReady === 1'b1) chk("commBufEn_n", 8'h00, {7'h0, commBufEn_n});
      if (link.hostReady === 1'b1) hr = k;
      if (link.hostReady === 1'b1) chk("hostBufEn_n", 8'h00, {7'h0, hostBufEn_n});
      @(negedge ref_clk);
      if (cr >= 0) commReq = 1'b0;
      if (userBusy === 1'b1) userReq = 1'b0;
    end
    chk("comm first", 8'h01, {7'h0, cr >= 0 && cr < hr});
    chk("stall gap", 8'h04, 8'(hr - cr));
    comm_acc(1'b0, 16'h0001, 8'h00);
    chk("ram 1", 8'h11, commRdata);
    host_acc(1'b0, 16'h0002, 8'h00);
    chk("ram 2", 8'h22, userRdata);
  endtask
  task automatic t_shared();
    fork
      host_acc(1'b1, 16'h0003, 8'ha5);
      begin
        repeat (3) @(negedge ref_clk);
        comm_acc(1'b1, 16'h0004, 8'h3c);
      end
    join
    comm_acc(1'b0, 16'h0003, 8'h00);
    chk("ram 3", 8'ha5, commRdata);
    host_acc(1'b0, 16'h0004, 8'h00);
    chk("ram 4", 8'h3c, userRdata);
  endtask
  task automatic t_irq();
    commIrqSetHost = 1'b1;
    @(negedge ref_clk);
    commIrqSetHost = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("userIrq set", 8'h01, {7'h0, userIrq});
    userIrqAck = 1'b1;
    @(negedge ref_clk);
    userIrqAck = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("userIrq clr", 8'h00, {7'h0, userIrq});
    userRaiseIrq = 1'b1;
    @(negedge ref_clk);
    userRaiseIrq = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("commIrq set", 8'h01, {7'h0, commIrqPending});
    commIrqAck = 1'b1;
    @(negedge ref_clk);
    commIrqAck = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("commIrq clr", 8'h00, {7'h0, commIrqPending});
  endtask
  task automatic t_strobes();
    int k, nSel, nOe, nWr, nDoe, nBuf, nLat;
    nSel = 0;
    nOe = 0;
    nWr = 0;
    nDoe = 0;
    nBuf = 0;
    nLat = 0;
    fork
      comm_acc(1'b0, 16'h0003, 8'h00);
      for (k = 0; k < 8; k++) begin
        @(negedge ref_clk);
        nSel += int'(ramSel_n === 1'b0);
        nOe += int'(ramOutEn_n === 1'b0);
        nWr += int'(ramWrEn_n === 1'b0);
        nLat += int'(commRdLatch === 1'b1);
      end
    join
    chk("read select", 8'(smc_pkg::SMC_CYC_CLKS), 8'(nSel));
    chk("read enable", 8'(smc_pkg::SMC_CYC_CLKS), 8'(nOe));
    chk("read wstrobe", 8'h00, 8'(nWr));
    chk("read latch", 8'h01, 8'(nLat));
    chk("ram 3 again", 8'ha5, commRdata);
    fork
      host_acc(1'b1, 16'h0005, 8'h5a);
      for (k = 0; k < 8; k++) begin
        @(negedge ref_clk);
        nWr += int'(ramWrEn_n === 1'b0);
        nDoe += int'(ramDataOe_n === 1'b0);
        nBuf += int'(hostBufEn_n === 1'b0);
        nLat += int'(hostRdLatch === 1'b1);
      end
    join
    chk("write wstrobe", 8'(smc_pkg::SMC_CYC_CLKS - 1), 8'(nWr));
    chk("write drive", 8'(smc_pkg::SMC_CYC_CLKS), 8'(nDoe));
    chk("host buffer", 8'(smc_pkg::SMC_CYC_CLKS), 8'(nBuf));
    chk("write latch", 8'h01, 8'(nLat));
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    rst = 1'b1;
    {userReq, userWrite, userIrqAck, userRaiseIrq} = 4'h0;
    {commReq, commWrite, commIrqSetHost, commIrqAck} = 4'h0;
    {userAddr, commAddr, userWdata, commWdata} = 48'h0;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    // conflict first so the reset favour is still in force
    t_conflict();
    t_shared();
    t_strobes();
    t_irq();
    results();
  end
endmodule // testbench
